// ### logic/sensor_params.svh
// Purpose: Shared constants of the serial register port and its controller.
// Assumes: pclk runs at 50 MHz.
// Notes:   Counts above 4096 cycles are defaults of module parameters.
`ifndef SENSOR_PARAMS_SVH
`define SENSOR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map of the sensor
// ----------------------------------------------------------------------
`define CFG_ADDR        7'h40
`define CFG_RESET       8'h00
`define PD_POS          6
`define SOFT_RESET_POS  7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define T_CLK_NS        20
`define SYS_CLK_KHZ     24000
`define PD_ENTRY_SYS    32
`define PD_ENTRY_CYC    ((`PD_ENTRY_SYS * 1000000 + `SYS_CLK_KHZ * `T_CLK_NS - 1) / (`SYS_CLK_KHZ * `T_CLK_NS))
`define READ_PREP_US    100
`define READ_PREP_CYC   ((`READ_PREP_US * 1000 + `T_CLK_NS - 1) / `T_CLK_NS)
`define PD_EXIT_MS      50
`define PD_EXIT_CYC     ((`PD_EXIT_MS * 1000000 + `T_CLK_NS - 1) / `T_CLK_NS)
`define TIMEOUT_MS      90
`define TIMEOUT_CYC     ((`TIMEOUT_MS * 1000000) / `T_CLK_NS)
`define SCK_HALF_CYC    8

// ----------------------------------------------------------------------
// Controller registers on APB
// ----------------------------------------------------------------------
`define CMD_OFS         12'h000
`define STAT_OFS        12'h004
`define CMD_GO_POS      16
`define CMD_WR_POS      15

`endif

// ### logic/sensor_pkg.sv
// Purpose: Types shared by both ends of the serial register port.
// Assumes: Nothing beyond the constants header.
// Notes:   State codes are written out.
package sensor_pkg;
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_LOW  = 3'b001,
		H_HIGH = 3'b010,
		H_GAP  = 3'b011,
		H_WAIT = 3'b100
	} host_state_e;
endpackage : sensor_pkg

// ### logic/sensor_link_if.sv
// Purpose: Two-wire link between the serial master and the sensor.
// Assumes: The data wire has a pull-up.
// Notes:   The shared data level is resolved here from the enables.
interface sensor_link_if;
	logic sck;
	logic host_sdio_o;
	logic host_sdio_oe;
	logic dev_sdio_o;
	logic dev_sdio_oe;
	logic shutter_o;
	logic shutter_oe;
	logic sdio;

	// Host wins a collision; an undriven wire reads as the pull-up.
	assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);

	modport host (output sck, output host_sdio_o, output host_sdio_oe, input sdio);
	modport device (input sck, input sdio, output dev_sdio_o, output dev_sdio_oe,
		output shutter_o, output shutter_oe);
endinterface : sensor_link_if

// ### logic/link_sync.sv
// Purpose: Two-flop synchroniser for a group of link levels.
// Assumes: Inputs are asynchronous to pclk.
// Notes:   The first stage feeds only the second.
module link_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta;

	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				meta[i]     <= 1'b1;
				sync_out[i] <= 1'b1;
			end else begin
				meta[i]     <= async_in[i];
				sync_out[i] <= meta[i];
			end
		end
	end
endmodule : link_sync

// ### logic/sensor_device.sv
// Purpose: Sensor end of the two-wire register port, with power-down control.
// Assumes: The link is sampled by pclk; the master keeps its timing.
// Notes:   Only the configuration register is implemented.
//
// Function
// RULE_01: Bit 6 write enters or leaves power-down.
// RULE_02: Host rewrites other bits unchanged when powering down.
// RULE_03: Host waits 32 system clocks after power-down.
// RULE_04: No timeout in power-down; no partial commands.
// RULE_05: In power-down only bit 6 is written.
// RULE_06: Host waits 50 ms after leaving power-down.
// RULE_07: Register contents survive power-down.
// RULE_08: Configuration register lives at address 0x40.
// RULE_09: Power-down releases shutter and data pins.
// RULE_10: Host starts transfers and makes the clock.
// RULE_11: Write: direction one, address, then data.
// RULE_12: Data changes on fall, sampled on rise.
// RULE_13: Read: direction zero, address, device returns data.
// RULE_14: Host releases data after last address bit.
// RULE_15: Device releases data after last data bit.
// RULE_16: Host waits 100 us before data clocks.
// RULE_17: Last data bit held until next fall.
// RULE_18: Port resets after 90 ms incomplete transaction.
// RULE_19: Unmapped writes ignored, unmapped reads zero; reads here are decoded from the previous command's address.
// RULE_20: Writing 0x80 soft-resets, bit clears itself.
// RULE_21: Eight bits per byte, MSB first.
`include "sensor_params.svh"

module sensor_device
	import sensor_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Link
	sensor_link_if.device link,
	// Sensor core view
	output logic [7:0] configuration,
	output logic       power_down,
	output logic       soft_reset_pulse
);
	// ------------------------------------------------------------------
	// Link sampling
	// ------------------------------------------------------------------
	logic [1:0] pins_s;
	logic       sck_s;
	logic       sdio_s;
	logic       sck_d;
	logic       rise;
	logic       fall;

	link_sync #(.W(2)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({link.sck, link.sdio}),
		.sync_out (pins_s)
	);

	assign sck_s  = pins_s[1];
	assign sdio_s = pins_s[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_d <= 1'b1;
		end else begin
			sck_d <= sck_s;
		end
	end

	// The host alone moves the clock, so every edge seen here is its doing. [RULE_10]
	assign rise = sck_s & ~sck_d;
	assign fall = ~sck_s & sck_d;

	// ------------------------------------------------------------------
	// Transaction framing and timeout
	// ------------------------------------------------------------------
	logic [3:0]  bit_cnt;
	logic [7:0]  shift_in;
	logic        active;
	logic [31:0] tmo_cnt;
	logic        tmo_hit;
	logic        is_read;
	logic [6:0]  addr;
	logic        addr_done;
	logic        data_done;
	logic        wr_apply;

	// Timer frozen while powered down: a partial command there hangs the port.
	assign tmo_hit   = active && !power_down &&
		(tmo_cnt >= TIMEOUT_CYCLES - 32'd1);                     // [RULE_18] [RULE_04]
	assign addr_done = rise && (bit_cnt == 4'd7);
	assign data_done = rise && (bit_cnt == 4'd15);
	assign wr_apply  = data_done && !is_read;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active  <= 1'b0;
			tmo_cnt <= 32'd0;
		end else if (tmo_hit || data_done) begin
			active  <= 1'b0;
			tmo_cnt <= 32'd0;
		end else if (!active && (rise || fall)) begin
			active  <= 1'b1;
			tmo_cnt <= 32'd0;
		end else if (active && !power_down) begin
			tmo_cnt <= tmo_cnt + 32'd1;                           // [RULE_18]
		end
	end

	// Bits enter MSB first, one per rising edge. [RULE_12] [RULE_21]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt  <= 4'd0;
			shift_in <= 8'h00;
		end else if (tmo_hit) begin
			bit_cnt  <= 4'd0;
		end else if (rise) begin
			shift_in <= {shift_in[6:0], sdio_s};
			bit_cnt  <= bit_cnt + 4'd1;
		end
	end

	// First byte: direction then seven address bits. [RULE_11] [RULE_13]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			is_read <= 1'b0;
			addr    <= 7'h00;
		end else if (addr_done) begin
			is_read <= ~shift_in[6];
			addr    <= {shift_in[5:0], sdio_s};
		end
	end

	// ------------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------------
	logic [7:0] wdata;
	logic       cfg_hit;

	assign wdata   = {shift_in[6:0], sdio_s};
	assign cfg_hit = (addr == `CFG_ADDR);                         // [RULE_08]

	// Unmapped writes fall through untouched. [RULE_19]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			configuration    <= `CFG_RESET;
			soft_reset_pulse <= 1'b0;
		end else begin
			soft_reset_pulse <= 1'b0;
			if (wr_apply && cfg_hit) begin
				if (configuration[`PD_POS]) begin
					// Only the power-down bit may change while powered down. [RULE_05]
					configuration[`PD_POS] <= wdata[`PD_POS];      // [RULE_01]
				end else if (wdata[`SOFT_RESET_POS]) begin
					// Reset bit is never stored, so it reads back clear. [RULE_20]
					configuration    <= wdata & ~(8'h01 << `SOFT_RESET_POS);
					soft_reset_pulse <= 1'b1;
				end else begin
					configuration <= wdata;                       // [RULE_01]
				end
			end
		end
	end

	// Nothing else touches the register, so it survives power-down. [RULE_07]
	assign power_down = configuration[`PD_POS];

	// ------------------------------------------------------------------
	// Read data return
	// ------------------------------------------------------------------
	logic [7:0] shift_out;
	logic       reading;
	logic       hold_last;
	logic       sdio_o;
	logic       sdio_oe;

	// The data byte is launched on the falls that precede rises 9 to 16.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_out <= 8'h00;
			reading   <= 1'b0;
			hold_last <= 1'b0;
			sdio_o    <= 1'b1;
			sdio_oe   <= 1'b0;
		end else if (tmo_hit || power_down) begin
			reading   <= 1'b0;
			hold_last <= 1'b0;
			sdio_oe   <= 1'b0;                                    // [RULE_09]
		end else if (addr_done) begin
			// Read data follows the previous command's address: the register if that was 0x40, else zeros. [RULE_19]
			shift_out <= cfg_hit ? configuration : 8'h00;
			reading   <= ~shift_in[6];                            // [RULE_13]
		end else if (fall && reading) begin
			sdio_o    <= shift_out[7];                            // [RULE_21]
			sdio_oe   <= 1'b1;                                    // [RULE_12]
			shift_out <= {shift_out[6:0], 1'b0};
		end else if (fall && hold_last) begin
			// The fall that opens the next command ends the hold. [RULE_15] [RULE_17]
			hold_last <= 1'b0;
			sdio_oe   <= 1'b0;
		end else if (data_done && reading) begin
			reading   <= 1'b0;
			hold_last <= 1'b1;                                    // [RULE_17]
		end
	end

	// ------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------
	logic shutter_oe;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shutter_oe <= 1'b0;
		end else begin
			shutter_oe <= ~power_down;                            // [RULE_09]
		end
	end

	assign link.dev_sdio_o  = sdio_o;
	assign link.dev_sdio_oe = sdio_oe;
	assign link.shutter_o   = 1'b1;
	assign link.shutter_oe  = shutter_oe;
endmodule : sensor_device

// ### logic/serial_host.sv
// Purpose: Serial master for the sensor port, commanded over APB.
// Assumes: APB3 with a single-cycle access; pclk at 50 MHz.
// Notes:   The master enforces the read, power-down and command spacings.
`include "sensor_params.svh"

module serial_host
	import sensor_pkg::*;
#(
	parameter int unsigned READ_PREP_CYCLES = `READ_PREP_CYC,
	parameter int unsigned PD_EXIT_CYCLES   = `PD_EXIT_CYC
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Link
	sensor_link_if.host      link
);
	// ------------------------------------------------------------------
	// Link state
	// ------------------------------------------------------------------
	host_state_e state;
	logic [15:0] frame;
	logic [3:0]  bit_no;
	logic [31:0] cnt;
	logic [7:0]  rx;
	logic        pd_state;
	logic        sck;
	logic        sdio_o;
	logic        sdio_oe;
	logic [0:0]  pins_s;
	logic        go;
	logic        rd;

	link_sync #(.W(1)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (link.sdio),
		.sync_out (pins_s)
	);

	// ------------------------------------------------------------------
	// APB registers
	// ------------------------------------------------------------------
	logic access;

	assign access = psel & penable & pready;
	assign go     = access & pwrite & (paddr == `CMD_OFS) & pwdata[`CMD_GO_POS] &
		(state == H_IDLE);
	assign rd     = ~frame[15];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr != `CMD_OFS) & (paddr != `STAT_OFS);
			if (psel && !penable && paddr == `STAT_OFS) begin
				prdata <= {16'h0, rx, 6'h0, pd_state, (state != H_IDLE)};
			end else if (psel && !penable && paddr == `CMD_OFS) begin
				prdata <= {16'h0, frame};
			end else begin
				prdata <= 32'h0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Frame engine
	// ------------------------------------------------------------------
	// The clock idles high; every command opens with a fall. [RULE_10]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= H_IDLE;
			frame    <= 16'h0;
			bit_no   <= 4'd0;
			cnt      <= 32'd0;
			rx       <= 8'h00;
			pd_state <= 1'b0;
			sck      <= 1'b1;
			sdio_o   <= 1'b1;
			sdio_oe  <= 1'b0;
		end else begin
			unique case (state)
				H_IDLE: begin
					if (go) begin
						// Direction bit leads, MSB first. [RULE_11] [RULE_13] [RULE_21]
						// The driver stays off until the sensor has dropped a held bit.
						frame   <= pwdata[15:0];
						bit_no  <= 4'd0;
						cnt     <= 32'd0;
						sck     <= 1'b0;
						sdio_o  <= pwdata[15];
						sdio_oe <= 1'b0;
						state   <= H_LOW;
					end
				end
				H_LOW: begin
					cnt <= cnt + 32'd1;
					// The sensor frees the line some pclk after the opening fall. [RULE_17]
					if (bit_no == 4'd0 && cnt == `SCK_HALF_CYC / 2) begin
						sdio_oe <= 1'b1;
					end
					if (cnt == `SCK_HALF_CYC - 1) begin
						cnt   <= 32'd0;
						sck   <= 1'b1;
						state <= H_HIGH;
					end
				end
				H_HIGH: begin
					cnt <= cnt + 32'd1;
					if (cnt == `SCK_HALF_CYC - 1) begin
						cnt <= 32'd0;
						if (rd && bit_no >= 4'd8) begin
							rx <= {rx[6:0], pins_s[0]};
						end
						if (bit_no == 4'd15) begin
							sdio_oe <= 1'b0;
							if (!rd && frame[14:8] == `CFG_ADDR) begin
								pd_state <= frame[`PD_POS];
							end
							state <= H_WAIT;
						end else if (rd && bit_no == 4'd7) begin
							// Let go of data and give the sensor time to fetch. [RULE_14] [RULE_16]
							sdio_oe <= 1'b0;
							state   <= H_GAP;
						end else begin
							// New bit goes out right after the fall. [RULE_12]
							sck    <= 1'b0;
							bit_no <= bit_no + 4'd1;
							sdio_o <= frame[4'd14 - bit_no];
							state  <= H_LOW;
						end
					end
				end
				H_GAP: begin
					cnt <= cnt + 32'd1;
					if (cnt >= READ_PREP_CYCLES - 32'd1) begin
						cnt    <= 32'd0;
						sck    <= 1'b0;
						bit_no <= bit_no + 4'd1;
						state  <= H_LOW;
					end
				end
				H_WAIT: begin
					cnt <= cnt + 32'd1;
					// Any configuration write with bit 6 clear gets the long settle; entering power-down and
					// every other command wait the 32 sensor clocks plus READ_PREP_CYCLES.
					if ((pd_state || !(frame[15] && frame[14:8] == `CFG_ADDR) ?
						cnt >= `PD_ENTRY_CYC + READ_PREP_CYCLES :
						cnt >= PD_EXIT_CYCLES)) begin                 // [RULE_03] [RULE_06]
						cnt   <= 32'd0;
						state <= H_IDLE;
					end
				end
				default: begin
					state <= H_IDLE;
				end
			endcase
		end
	end

	assign link.sck          = sck;
	assign link.host_sdio_o  = sdio_o;
	assign link.host_sdio_oe = sdio_oe;
endmodule : serial_host

// ### tb/sensor_link_assertions.sv
// Purpose: Concurrent checks on the two-wire link between master and sensor.
// Assumes: Both ends run on pclk; sck is a level made by the master.
// Notes:   Takes the link signals as plain inputs; no bind.
module sensor_link_assertions (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link
	input wire logic sck,
	input wire logic host_sdio_o,
	input wire logic host_sdio_oe,
	input wire logic dev_sdio_o,
	input wire logic dev_sdio_oe,
	input wire logic shutter_o,
	input wire logic shutter_oe,
	input wire logic sdio
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------------
	sequence s_dev_takes;
		$rose(dev_sdio_oe);
	endsequence
	sequence s_dev_leaves;
		$fell(dev_sdio_oe);
	endsequence
	sequence s_high_phase;
		$rose(sck) ##1 sck [*7];
	endsequence

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_pd_pins_off: assert property (!shutter_oe |-> !dev_sdio_oe)
		else $error("sensor drives data while powered down");
	a_no_bus_fight: assert property (!(host_sdio_oe && dev_sdio_oe))
		else $error("both ends drive the data line");
	a_dev_start_low: assert property (s_dev_takes |-> !sck && !host_sdio_oe)
		else $error("sensor took the data line out of turn");
	a_host_data_hold: assert property (host_sdio_oe && sck && $past(sck)
		|-> $stable(host_sdio_o))
		else $error("master changed data while clock high");
	a_dev_data_hold: assert property (dev_sdio_oe && sck && $past(sck)
		|-> $stable(dev_sdio_o))
		else $error("sensor changed data while clock high");
	a_dev_release: assert property (s_dev_leaves |-> !sck)
		else $error("sensor released data before a clock fall");
	a_sck_high_len: assert property ($rose(sck) |=> sck [*7])
		else $error("clock high phase too short");
	a_sck_low_len: assert property ($fell(sck) |=> !sck [*7])
		else $error("clock low phase too short");
	c_dev_read: cover property (s_dev_takes);
	c_high: cover property (s_high_phase);
endmodule : sensor_link_assertions

// ### tb/sensor_serial_port_powerdown_test.sv
// Purpose: Self-checking bench: APB commands, link transfers, power-down.
// Assumes: Master answers APB in one access cycle; counts shortened.
// Notes:   Table rows drive commands; reset and refusals are hand-written.
`include "sensor_params.svh"

module sensor_serial_port_powerdown_test;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		logic       wr;
		logic [6:0] addr;
		logic [7:0] data;
		logic [7:0] exp_cfg;
		logic [7:0] exp_rd;
	} row_s;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  configuration;
	logic        power_down;
	logic        soft_reset_pulse;
	int          failures;
	int          samples_checked;
	int          pulses;
	logic [31:0] d;
	logic        e;
	row_s        rows [9];

	sensor_link_if link ();

	serial_host #(.READ_PREP_CYCLES(64), .PD_EXIT_CYCLES(200)) i_serial_host (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link));

	sensor_device #(.TIMEOUT_CYCLES(2000)) i_sensor_device (
		.pclk(pclk), .presetn(presetn), .link(link), .configuration(configuration),
		.power_down(power_down), .soft_reset_pulse(soft_reset_pulse));

	sensor_link_assertions i_sensor_link_assertions (
		.pclk(pclk), .presetn(presetn), .sck(link.sck), .host_sdio_o(link.host_sdio_o),
		.host_sdio_oe(link.host_sdio_oe), .dev_sdio_o(link.dev_sdio_o),
		.dev_sdio_oe(link.dev_sdio_oe), .shutter_o(link.shutter_o),
		.shutter_oe(link.shutter_oe), .sdio(link.sdio));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (soft_reset_pulse === 1'b1) begin
			pulses++;
		end
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One APB transfer; the master holds everything until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				rd = prdata;
				err = pslverr;
				psel    <= 1'b0;
				penable <= 1'b0;
				return;
			end
		end
		failures++;
		test_done();
	endtask : apb

	// Poll busy with a bound; a transfer plus its spacing is well under it.
	task automatic wait_idle();
		for (int i = 0; i < 3000; i++) begin
			apb(1'b0, `STAT_OFS, 32'h0, d, e);
			if (d[0] === 1'b0) begin
				return;
			end
		end
		failures++;
		test_done();
	endtask : wait_idle

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		failures = 0;
		samples_checked = 0;
		pulses = 0;
		// The power-down rows rewrite the other bits unchanged on entry.
		rows[0] = '{1'b1, `CFG_ADDR, 8'h15, 8'h15, 8'h00};
		rows[1] = '{1'b0, `CFG_ADDR, 8'h00, 8'h15, 8'h15};
		rows[2] = '{1'b1, 7'h77, 8'h00, 8'h15, 8'h00};
		rows[3] = '{1'b0, 7'h41, 8'h00, 8'h15, 8'h00};
		rows[4] = '{1'b1, `CFG_ADDR, 8'h55, 8'h55, 8'h00};
		rows[5] = '{1'b1, `CFG_ADDR, 8'h4a, 8'h55, 8'h00};
		rows[6] = '{1'b1, `CFG_ADDR, 8'h2a, 8'h15, 8'h00};
		rows[7] = '{1'b1, `CFG_ADDR, 8'h80, 8'h00, 8'h00};
		rows[8] = '{1'b0, `CFG_ADDR, 8'h00, 8'h00, 8'h00};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		@(negedge pclk);
		check("cfg reset", {24'h0, configuration}, 32'h0);
		check("sck idle", {31'h0, link.sck}, 32'h1);
		check("shutter on", {31'h0, link.shutter_oe}, 32'h1);
		for (int r = 0; r < 9; r++) begin
			apb(1'b1, `CMD_OFS, {15'h0, 1'b1, rows[r].wr, rows[r].addr, rows[r].data}, d, e);
			wait_idle();
			check("cfg", {24'h0, configuration}, {24'h0, rows[r].exp_cfg});
			check("pd", {31'h0, power_down}, {31'h0, rows[r].exp_cfg[6]});
			check("shutter pd", {31'h0, link.shutter_oe}, {31'h0, ~rows[r].exp_cfg[6]});
			check("dev oe", {31'h0, link.dev_sdio_oe}, {31'h0, ~rows[r].wr});
			check("host pd", {31'h0, d[1]}, {31'h0, rows[r].exp_cfg[6]});
			if (rows[r].wr === 1'b0) begin
				check("rd byte", {24'h0, d[15:8]}, {24'h0, rows[r].exp_rd});
			end
		end
		check("soft pulses", pulses, 32'h1);
		apb(1'b0, 12'h008, 32'h0, d, e);
		check("unmapped err", {31'h0, e}, 32'h1);
		check("unmapped data", d, 32'h0);
		apb(1'b1, 12'h00c, 32'h1ffff, d, e);
		check("unmapped wr err", {31'h0, e}, 32'h1);
		check("no go", {24'h0, configuration}, 32'h0);
		apb(1'b1, `CMD_OFS, {15'h0, 1'b1, 1'b1, `CFG_ADDR, 8'h0c}, d, e);
		// A second go while the frame runs must be dropped by the master.
		apb(1'b1, `CMD_OFS, {15'h0, 1'b1, 1'b1, `CFG_ADDR, 8'h3f}, d, e);
		wait_idle();
		check("busy go", {24'h0, configuration}, 32'h0000000c);
		apb(1'b0, `CMD_OFS, 32'h0, d, e);
		check("last frame", {16'h0, d[15:0]}, {16'h0, 1'b1, `CFG_ADDR, 8'h0c});
		// Reset in mid-frame, then a fresh write after release.
		apb(1'b1, `CMD_OFS, {15'h0, 1'b1, 1'b1, `CFG_ADDR, 8'h33}, d, e);
		repeat (100) @(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		@(negedge pclk);
		check("mid reset cfg", {24'h0, configuration}, 32'h0);
		check("mid reset sck", {31'h0, link.sck}, 32'h1);
		check("mid reset oe", {31'h0, link.host_sdio_oe}, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		@(negedge pclk);
		check("rel shutter", {31'h0, link.shutter_oe}, 32'h1);
		apb(1'b1, `CMD_OFS, {15'h0, 1'b1, 1'b1, `CFG_ADDR, 8'h21}, d, e);
		wait_idle();
		check("after reset", {24'h0, configuration}, 32'h00000021);
		test_done();
	end
endmodule : sensor_serial_port_powerdown_test
